/* File: testbench/interrupt_split_descriptor_decode_tb.sv */
// Self-checking bench for the interrupt split descriptor decoder
`timescale 1ns/1ps
module interrupt_split_descriptor_decode_tb;
  import isd_pkg::*;
  localparam int MC = 10;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} isd_note_t;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, txn_req, txn_split, txn_low_speed, txn_done, txn_ok, txn_fatal;
  logic [1:0]  txn_token, mode = 2'h0;
  logic [6:0]  txn_function;
  logic [3:0]  txn_endpoint;
  logic [10:0] txn_max_payload, txn_bytes, bcmd = 11'h000;
  int          n_fail = 0, checked = 0, n_req = 0, cyc = 0, seed = 32'hd19f;
  isd_note_t   q[$];
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (txn_req === 1'b1) n_req++;
  end
  isd_top #(.MICRO_CYCLES(MC)) dut_u (.*);
  isd_fs_device_model peer_u (.*);
  task automatic cmp32(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t data %h expected %h", $time, got, exp);
    end
  endtask : cmp32
  task automatic cmp1(input logic got, exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp1
  // One idle cycle after each transfer keeps every strobe to one assignment per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, ed, em, input logic ee);
    int n;
    q.push_back('{ed & em, em, ee});
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t no pready", $time);
    end
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d, 32'h0, 32'h0, ee);
  endtask : wr
  task automatic rdw(input logic [7:0] a, input logic [31:0] ed, em);
    apb(1'b0, a, 32'h0, ed, em, 1'b0);
  endtask : rdw
  always @(posedge clk) begin
    if (pready === 1'b1 && q.size() > 0) begin
      cmp1(pslverr, q[0].e);
      cmp32(prdata & q[0].m, q[0].d);
      void'(q.pop_front());
    end
  end
  task automatic tally_and_finish();
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
  // Cases 0-3 refused, 4-7 plain, 8 retried failure, 9 fatal
  initial begin
    logic [31:0] lo, hi, dw;
    logic [14:0] bud;
    int          per, t0, n;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdw(ADDR_STATUS, 32'h0, 32'hffffffff);
    rdw(ADDR_CTRL, 32'h0, 32'hffffffff);
    wr(8'h1c, 32'h0, 1'b1);
    for (int i = 0; i < 10; i++) begin
      bud = 15'(1 + {$random(seed)} % 64);
      per = (1 << (3 + i % 2)) * MC;
      hi = {14'h0, ($random(seed) & 1) ? RATE_LOW : RATE_FULL, 1'b0, i[1] && i < 8, KIND_INTR,
            i[0] ? TOK_IN : TOK_OUT, 7'($random(seed)), 3'($random(seed))};
      lo = {1'($random(seed)), 2'($random(seed)), MPS_FS_MAX, bud, 2'($random(seed)), 1'b1};
      dw = {7'h0, i < 8 ? 2'h3 : 2'h1, 15'h0, 5'(4 + i % 2), 3'h0};
      case (i)
        0: hi[13:12] = 2'h2;
        1: hi[11:10] = 2'h2;
        2: lo[28:18] = MPS_FS_MAX + 11'h1;
        3: lo[17:3] = BUDGET_MAX + 15'h1;
        default: ;
      endcase
      mode <= i < 8 ? 2'h0 : (i == 8 ? 2'h1 : 2'h2);
      slow <= i[0];
      bcmd <= 11'(bud);
      wr(ADDR_DESC_DW2, dw, 1'b0);
      wr(ADDR_DESC_HI, hi, 1'b0);
      n_req = 0;
      wr(ADDR_DESC_LO, lo, 1'b0);
      t0 = cyc;
      if (i < 4) begin
        // The check state loads the error code on the next edge; the bench waits two before reading it
        repeat (2) @(posedge clk);
        rdw(ADDR_STATUS, 32'(4'h1 << i), 32'hf);
        rdw(ADDR_DESC_LO, 32'h1, 32'h1);
        cmp32(32'(n_req), 32'h0);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
      end else begin
        if (i == 4) wr(ADDR_DESC_HI, ~hi, 1'b1);
        n = 0;
        while (txn_req !== 1'b1 && n < 1000) begin
          @(posedge clk);
          n++;
        end
        cmp1(cyc - t0 >= per - 2 && cyc - t0 <= per + 6, 1'b1);
        if (i < 8) rdw(ADDR_TOKEN, {18'h0, hi[11:10], 1'b0, hi[9:3], hi[2:0], lo[31]}, 32'hffffffff);
        if (i < 8) rdw(ADDR_SPLIT, {29'h0, hi[14], hi[17:16]}, 32'hffffffff);
        n = 0;
        do begin
          rdw(ADDR_DESC_LO, 32'h0, 32'h0);
          n++;
        end while (rd[0] !== 1'b0 && n < 100);
        rdw(ADDR_DESC_LO, lo & ~32'h1, 32'hffffffff);
        if (i < 8) rdw(ADDR_STATUS, {11'h0, 2'h3, bud, 4'h0}, 32'hffffffff);
        else cmp32(32'(n_req), i == 8 ? 32'h2 : 32'h1);
      end
    end
    tally_and_finish();
  end
endmodule : interrupt_split_descriptor_decode_tb

/* File: testbench/isd_fs_device_model.sv */
// Behavioural full/low-speed target answering issued transactions
`timescale 1ns/1ps
module isd_fs_device_model
  import isd_pkg::*;
(
  // Clock, reset and bench commands
  input  wire logic        clk, rst, slow,
  input  wire logic [1:0]  mode,
  input  wire logic [10:0] bcmd,
  // Transaction side
  input  wire logic        txn_req,
  input  wire logic [10:0] txn_max_payload,
  output logic             txn_done, txn_ok, txn_fatal,
  output logic [10:0]      txn_bytes
);
  logic       pend;
  logic [2:0] wait_n;
  // Result lines toggle outside the done pulse, so a stale value is never mistaken for an answer
  always_ff @(posedge clk) begin
    txn_done  <= 1'b0;
    txn_ok    <= ~txn_ok;
    txn_fatal <= ~txn_fatal;
    txn_bytes <= ~txn_bytes;
    if (rst) begin
      pend <= 1'b0;
      wait_n <= 3'h0;
      {txn_ok, txn_fatal, txn_bytes} <= 13'h0;
    end else if (txn_req) begin
      pend   <= 1'b1;
      wait_n <= slow ? 3'h6 : 3'h0;
    end else if (pend && wait_n != 3'h0) begin
      wait_n <= wait_n - 3'h1;
    end else if (pend) begin
      pend      <= 1'b0;
      txn_done  <= 1'b1;
      txn_ok    <= mode == 2'h0;
      txn_fatal <= mode == 2'h2;
      txn_bytes <= (bcmd > txn_max_payload) ? txn_max_payload : bcmd;
    end
  end
endmodule : isd_fs_device_model

/* File: testbench/isd_sva.sv */
// Port-level assertions for the interrupt split descriptor decoder
`timescale 1ns/1ps
module isd_sva
  import isd_pkg::*;
#(
  parameter int MICRO_CYCLES = 10
) (
  // Clock, reset and APB
  input wire logic        clk, rst, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  // Transaction engine
  input wire logic        txn_req, txn_split, txn_low_speed, txn_done, txn_ok, txn_fatal,
  input wire logic [1:0]  txn_token,
  input wire logic [6:0]  txn_function,
  input wire logic [3:0]  txn_endpoint,
  input wire logic [10:0] txn_max_payload, txn_bytes
);
  // ****************
  // Shadow of accepted descriptor writes
  // ****************
  logic [31:0] hi, lo;
  logic        in_flight;
  wire         wr_ok = psel && penable && pready && pwrite && !pslverr;
  always_ff @(posedge clk) begin
    if (rst) begin
      hi        <= 32'h0;
      lo        <= 32'h0;
      in_flight <= 1'b0;
    end else begin
      if (wr_ok && paddr == ADDR_DESC_HI) hi <= pwdata;
      if (wr_ok && paddr == ADDR_DESC_LO) lo <= pwdata;
      in_flight <= txn_req || (in_flight && !txn_done);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_issue;
    txn_req;
  endsequence
  a_apb_no_wait: assert property (s_setup |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_unmapped_error: assert property (s_setup ##1 (paddr > ADDR_SPLIT) |-> pslverr) else $error("no slave error");
  a_split_select: assert property (s_issue |-> txn_split == hi[14])
    else $error("split flag wrong");
  a_intr_token: assert property (s_issue |-> hi[13:12] == KIND_INTR && !txn_token[1])
    else $error("bad kind or token issued");
  a_function_addr: assert property (s_issue |-> txn_function == hi[9:3] && txn_token == hi[11:10])
    else $error("function or token wrong");
  a_endpoint_join: assert property (s_issue |-> txn_endpoint == {hi[2:0], lo[31]})
    else $error("endpoint wrong");
  a_split_payload: assert property (txn_req && txn_split |-> txn_max_payload == lo[28:18]
    && txn_max_payload <= MPS_FS_MAX) else $error("payload size wrong");
  a_budget_limit: assert property (s_issue |-> lo[17:3] <= BUDGET_MAX) else $error("budget over");
  a_line_rate: assert property (txn_req && txn_split |-> txn_low_speed == (hi[17:16] == RATE_LOW))
    else $error("speed wrong");
  a_one_outstanding: assert property (s_issue |-> !in_flight) else $error("reissue before result");
endmodule : isd_sva
bind isd_top isd_sva #(.MICRO_CYCLES(MICRO_CYCLES)) chk_u (.*);

/* File: verilog/isd_pkg.sv */
// Constants, layouts and state types for the interrupt split descriptor decoder
package isd_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_DESC_LO = 8'h00;
  localparam logic [7:0] ADDR_DESC_HI = 8'h04;
  localparam logic [7:0] ADDR_DESC_DW2 = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_TOKEN = 8'h14;
  localparam logic [7:0] ADDR_SPLIT = 8'h18;

  // ****************************************
  // Descriptor field positions (64-bit word; poll and retry fields sit in DW2)
  // ****************************************
  localparam int POS_RATE_HI = 49;
  localparam int POS_RATE_LO = 48;
  localparam int POS_SPLIT = 46;
  localparam int POS_KIND_HI = 45;
  localparam int POS_KIND_LO = 44;
  localparam int POS_TOK_HI = 43;
  localparam int POS_TOK_LO = 42;
  localparam int POS_FUNC_HI = 41;
  localparam int POS_FUNC_LO = 35;
  localparam int POS_EPU_HI = 34;
  localparam int POS_EPU_LO = 32;
  localparam int POS_EP0 = 31;
  localparam int POS_MPS_HI = 28;
  localparam int POS_MPS_LO = 18;
  localparam int POS_BUD_HI = 17;
  localparam int POS_BUD_LO = 3;
  localparam int POS_ARMED = 0;
  localparam int POS_POLL_HI = 7;
  localparam int POS_POLL_LO = 3;
  localparam int POS_RETRY_HI = 24;
  localparam int POS_RETRY_LO = 23;

  // ****************************************
  // Codes and limits
  // ****************************************
  localparam logic [1:0] TOK_OUT = 2'h0;
  localparam logic [1:0] TOK_IN = 2'h1;
  localparam logic [1:0] KIND_INTR = 2'h3;
  localparam logic [1:0] RATE_LOW = 2'h2;
  localparam logic [1:0] RATE_FULL = 2'h0;
  localparam logic [10:0] MPS_FS_MAX = 11'h040;
  localparam logic [14:0] BUDGET_MAX = 15'h1000;
  localparam logic [4:0] POLL_B_MIN = 5'h04;
  localparam logic [4:0] POLL_B_MAX = 5'h10;
  localparam logic [3:0] ERR_BAD_KIND = 4'h1;
  localparam logic [3:0] ERR_BAD_TOKEN = 4'h2;
  localparam logic [3:0] ERR_BAD_MPS = 4'h4;
  localparam logic [3:0] ERR_BAD_BUDGET = 4'h8;
  localparam logic [31:0] MICRO_NS = 32'h000003e8 * 32'h0000007d;
  localparam logic [31:0] CLK_NS = 32'h00000005;

  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_WAIT, ST_ISSUE, ST_RESULT} isd_state_t;

endpackage : isd_pkg

/* File: verilog/isd_poll_timer.sv */
// Polling period timer counting microframes
`timescale 1ns/1ps
module isd_poll_timer
  import isd_pkg::*;
#(
  parameter int MICRO_CYCLES = 25000
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       start,
  input  wire logic [4:0] poll_b,
  // Result
  output logic            due
);

  // ****************************************
  // Microframe and period counters
  // ****************************************
  logic [31:0] cyc;
  logic [16:0] micro;
  logic [4:0]  b_eff;
  logic [16:0] period;
  logic        wrap;
  wire         tick = (cyc == 32'(MICRO_CYCLES - 1));

  // Out-of-range codes are clamped rather than refused, so scheduling never stalls
  assign b_eff  = (poll_b < POLL_B_MIN) ? POLL_B_MIN : ((poll_b > POLL_B_MAX) ? POLL_B_MAX : poll_b);
  assign period = 17'h00001 << (b_eff - 5'h01);
  // Restart the microframe count at each due, so later polls keep the full period
  assign wrap   = tick && (micro + 17'h1 >= period);

  always_ff @(posedge clk) begin
    if (rst || start) begin
      cyc   <= '0;
      micro <= '0;
      due   <= 1'b0;
    end else begin
      cyc   <= tick ? '0 : cyc + 32'h1;
      micro <= wrap ? '0 : (tick ? micro + 17'h1 : micro);
      due   <= wrap;
    end
  end

endmodule : isd_poll_timer

/* File: verilog/isd_top.sv */
// APB-reached interrupt split descriptor decoder and executor
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
module isd_top
  import isd_pkg::*;
#(
  parameter int MICRO_CYCLES = int'(MICRO_NS / CLK_NS)
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Transaction engine
  output logic             txn_req,
  output logic             txn_split,
  output logic             txn_low_speed,
  output logic [1:0]       txn_token,
  output logic [6:0]       txn_function,
  output logic [3:0]       txn_endpoint,
  output logic [10:0]      txn_max_payload,
  input  wire logic        txn_done,
  input  wire logic        txn_ok,
  input  wire logic        txn_fatal,
  input  wire logic [10:0] txn_bytes
);

  // ****************************************
  // Descriptor storage
  // ****************************************
  logic [63:0] desc;
  logic [31:0] dw2;
  logic [14:0] moved;
  logic [1:0]  retry;
  logic [3:0]  err_code;
  logic        busy;
  isd_state_t  state;
  isd_state_t  next_state;

  // ****************************************
  // Field decode
  // ****************************************
  wire        f_armed  = desc[POS_ARMED];
  wire        f_split  = desc[POS_SPLIT];
  wire [1:0]  f_kind   = desc[POS_KIND_HI:POS_KIND_LO];
  wire [1:0]  f_token  = desc[POS_TOK_HI:POS_TOK_LO];
  wire [6:0]  f_func   = desc[POS_FUNC_HI:POS_FUNC_LO];
  wire [3:0]  f_ep     = {desc[POS_EPU_HI:POS_EPU_LO], desc[POS_EP0]};
  wire [10:0] f_mps    = desc[POS_MPS_HI:POS_MPS_LO];
  wire [14:0] f_budget = desc[POS_BUD_HI:POS_BUD_LO];
  wire [1:0]  f_rate   = desc[POS_RATE_HI:POS_RATE_LO];
  wire [4:0]  f_poll   = dw2[POS_POLL_HI:POS_POLL_LO];
  wire [1:0]  f_retry  = dw2[POS_RETRY_HI:POS_RETRY_LO];

  // Sanity checks: descriptors breaking software limits are fatal, not guessed at
  wire bad_kind   = (f_kind != KIND_INTR);
  wire bad_token  = (f_token != TOK_OUT) && (f_token != TOK_IN);
  wire bad_mps    = f_split && (f_mps > MPS_FS_MAX);
  wire bad_budget = (f_budget > BUDGET_MAX);
  wire [3:0] chk  = (bad_kind ? ERR_BAD_KIND : 4'h0) | (bad_token ? ERR_BAD_TOKEN : 4'h0)
                  | (bad_mps ? ERR_BAD_MPS : 4'h0) | (bad_budget ? ERR_BAD_BUDGET : 4'h0);

  wire [14:0] moved_sum = moved + 15'(txn_bytes);
  wire        finished  = (moved_sum >= f_budget) || (txn_bytes < f_mps);

  // ****************************************
  // APB decode
  // ****************************************
  wire setup     = psel && !penable;
  wire access    = psel && penable;
  wire wr        = access && pwrite;
  wire hit_lo    = (paddr == ADDR_DESC_LO);
  wire hit_hi    = (paddr == ADDR_DESC_HI);
  wire hit_dw2   = (paddr == ADDR_DESC_DW2);
  wire hit_ctrl  = (paddr == ADDR_CTRL);
  wire hit_stat  = (paddr == ADDR_STATUS);
  wire hit_tok   = (paddr == ADDR_TOKEN);
  wire hit_split = (paddr == ADDR_SPLIT);
  wire mapped    = hit_lo | hit_hi | hit_dw2 | hit_ctrl | hit_stat | hit_tok | hit_split;
  // Descriptor writes while executing are refused, so the engine sees stable fields
  wire refuse    = busy && (hit_lo | hit_hi | hit_dw2);
  wire clr_armed = (state == ST_RESULT) && txn_done && (txn_fatal || (retry == 2'h0 && !txn_ok) || (txn_ok && finished));
  wire [31:0] rd_mux = hit_lo ? desc[31:0] : hit_hi ? desc[63:32] : hit_dw2 ? dw2 :
                       hit_stat ? {11'h0, f_retry == 2'h0 ? 2'h0 : retry, moved, err_code} :
                       hit_tok ? {18'h0, f_token, 1'b0, f_func, f_ep} :
                       hit_split ? {29'h0, f_split, f_rate} : 32'h0;
  wire rd_setup  = setup && !pwrite;
  wire wr_land   = wr && pready && !pslverr;

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && (!mapped || (pwrite && refuse));
      prdata  <= rd_setup ? rd_mux : prdata;
    end
  end

  // ****************************************
  // Descriptor register writes
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      desc <= 64'h0;
      dw2  <= 32'h0;
    end else begin
      // Hardware clear wins over a same-cycle software write of the low word
      if (wr_land && hit_lo) desc[31:0] <= pwdata;
      if (wr_land && hit_hi) desc[63:32] <= pwdata;
      if (wr_land && hit_dw2) dw2 <= pwdata;
      if (clr_armed) desc[POS_ARMED] <= 1'b0;
    end
  end

  // ****************************************
  // Engine events
  // ****************************************
  wire arm_seen  = (state == ST_IDLE) && f_armed;
  wire res_ok    = (state == ST_RESULT) && txn_done && txn_ok;
  wire res_retry = (state == ST_RESULT) && txn_done && !txn_ok && !txn_fatal && (retry != 2'h0);

  // ****************************************
  // Execution state machine
  // ****************************************
  logic poll_start;
  logic poll_due;

  isd_poll_timer #(
    .MICRO_CYCLES (MICRO_CYCLES)
  ) u_timer (
    .clk    (clk),
    .rst    (rst),
    .start  (poll_start),
    .poll_b (f_poll),
    .due    (poll_due)
  );

  always_comb begin
    next_state = state;
    poll_start = 1'b0;
    case (state)
      ST_IDLE: begin
        if (f_armed) next_state = ST_CHECK;
      end
      ST_CHECK: begin
        next_state = (chk != 4'h0) ? ST_IDLE : ST_WAIT;
        poll_start = 1'b1;
      end
      ST_WAIT: begin
        if (!f_armed) next_state = ST_IDLE;
        else if (poll_due) next_state = ST_ISSUE;
      end
      ST_ISSUE: begin
        next_state = ST_RESULT;
      end
      ST_RESULT: begin
        if (txn_done) begin
          if (clr_armed) next_state = ST_IDLE;
          else if (txn_ok) next_state = ST_WAIT;
          else next_state = ST_ISSUE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= ST_IDLE;
      busy     <= 1'b0;
      moved    <= 15'h0;
      retry    <= 2'h0;
      err_code <= 4'h0;
      txn_req  <= 1'b0;
    end else begin
      state   <= next_state;
      busy    <= (next_state != ST_IDLE);
      txn_req <= (next_state == ST_ISSUE);
      if (arm_seen) begin
        moved <= 15'h0;
        retry <= f_retry;
      end
      // Error code is reloaded at every check and held between checks, so a refused descriptor stays readable
      if (state == ST_CHECK) err_code <= chk;
      if (res_ok) moved <= moved_sum;
      if (res_retry) begin
        retry <= retry - 2'h1;
      end
    end
  end

  // ****************************************
  // Transaction outputs, registered from the descriptor
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      txn_split       <= 1'b0;
      txn_low_speed   <= 1'b0;
      txn_token       <= TOK_OUT;
      txn_function    <= 7'h0;
      txn_endpoint    <= 4'h0;
      txn_max_payload <= 11'h0;
    end else begin
      txn_split       <= f_split;
      txn_low_speed   <= f_split && (f_rate == RATE_LOW);
      txn_token       <= f_token;
      txn_function    <= f_func;
      txn_endpoint    <= f_ep;
      txn_max_payload <= f_mps;
    end
  end

endmodule : isd_top
